// >>> clkbuf_defines.svh
// offsets, field positions, reset values and addresses of the buffer
`ifndef CLKBUF_DEFINES_SVH
`define CLKBUF_DEFINES_SVH

// apb byte addresses
`define OFS_ENABLE0      12'h000
`define OFS_ENABLE1      12'h004
`define OFS_ENABLE2      12'h008
`define OFS_STATUS       12'h00C

// enable byte reset values, all used bits on
`define RST_ENABLE0      8'hFF
`define RST_ENABLE1      8'h1F
`define RST_ENABLE2      8'h3F

// serial byte offsets of the three enable bytes
`define IDX_ENABLE0      7'h00
`define IDX_ENABLE1      7'h01
`define IDX_ENABLE2      7'h02

// status word field positions
`define ST_MODE          0
`define ST_DDR_FB        1
`define ST_SDR_FB        2
`define ST_SER_BUSY      3

// two-wire slave address and command layout
`define SER_ADDR         7'h69
`define CMD_BYTE_BIT     7
`define BLOCK_COUNT      8'h03
`define BITS_PER_BYTE    4'h8

`endif

// >>> clkbuf_pkg.sv
// types shared by the clock buffer modules
package clkbuf_pkg;

  // phase of the two-wire slave
  typedef enum logic [2:0] {
    PH_IDLE,
    PH_ADDR,
    PH_CMD,
    PH_COUNT,
    PH_WDATA,
    PH_RDATA,
    PH_SKIP
  } ser_phase_e;

  // whole state of the top module
  typedef struct packed {
    logic [1:0]  mode_sy;
    logic [1:0]  ddr_fb_sy;
    logic [1:0]  sdr_fb_sy;
    logic [2:0]  scl_sy;
    logic [2:0]  sda_sy;
    logic [7:0]  en0;
    logic [7:0]  en1;
    logic [7:0]  en2;
    logic [31:0] prdata;
    logic        pslverr;
    ser_phase_e  phase;
    logic        ack;
    logic [3:0]  bitcnt;
    logic [7:0]  shift;
    logic [7:0]  cmd;
    logic [6:0]  ptr;
    logic        rd_first;
    logic        sda_oe_n;
    logic        touched;
  } core_s;

endpackage

// >>> gate_if.sv
// mode and enables passed from the control core to the gate array
`timescale 1ns/10ps
interface gate_if;
  logic        ddr_mode;
  logic [12:0] en_sdr;
  logic [5:0]  en_ddr;

  modport ctrl (output ddr_mode, output en_sdr, output en_ddr);
  modport gate (input ddr_mode, input en_sdr, input en_ddr);
endinterface

// >>> clock_gate_array.sv
// gates the reference clock onto the ddr and sdr output groups
`timescale 1ns/10ps
module clock_gate_array (
  // control clock, used only for checks
  input  wire logic        pclk,
  input  wire logic        presetn,
  // reference and control
  input  wire logic        reference_clock_in,
  gate_if.gate             g,
  // clock outputs
  output logic [5:0]       ddr_true_out,
  output logic [5:0]       ddr_comp_out,
  output logic             ddr_feedback_out,
  output logic [12:0]      sdr_out,
  output logic             sdr_feedback_out
);
  import clkbuf_pkg::*;

  // enables move with pclk, so a change can clip one reference pulse
  assign ddr_true_out     = {6{reference_clock_in & g.ddr_mode}}
                            & g.en_ddr;
  assign ddr_comp_out     = {6{~reference_clock_in & g.ddr_mode}}
                            & g.en_ddr;
  assign sdr_out          = {13{reference_clock_in & ~g.ddr_mode}}
                            & g.en_sdr;
  // feedback pins ignore the enables; board loop only comes back as status bits
  assign ddr_feedback_out = reference_clock_in & g.ddr_mode;
  assign sdr_feedback_out = reference_clock_in & ~g.ddr_mode;

  AST_SDR_OFF_IN_DDR: assert property (
    @(posedge pclk) disable iff (!presetn)
    g.ddr_mode |-> (sdr_out == 13'h0000 && !sdr_feedback_out))
    else $error("sdr group active in ddr mode");

  AST_DDR_OFF_IN_SDR: assert property (
    @(posedge pclk) disable iff (!presetn)
    !g.ddr_mode |-> (ddr_true_out == 6'h00 && ddr_comp_out == 6'h00
                     && !ddr_feedback_out))
    else $error("ddr group active in sdr mode");

  AST_TRUE_COPY: assert property (
    @(posedge pclk) disable iff (!presetn)
    (g.ddr_mode && g.en_ddr[0]) |-> ddr_true_out[0] == reference_clock_in)
    else $error("true output is not a copy of the reference");

  AST_COMP_PAIR: assert property (
    @(posedge pclk) disable iff (!presetn)
    g.ddr_mode |-> (ddr_comp_out == (~ddr_true_out & g.en_ddr)))
    else $error("complement output does not pair with true output");

  AST_FEEDBACK_RUNS: assert property (
    @(posedge pclk) disable iff (!presetn)
    (sdr_feedback_out | ddr_feedback_out) == reference_clock_in)
    else $error("feedback output does not follow the reference");

  AST_DISABLED_LOW: assert property (
    @(posedge pclk) disable iff (!presetn)
    ((sdr_out & ~g.en_sdr) == 13'h0000)
    && ((ddr_true_out & ~g.en_ddr) == 6'h00))
    else $error("disabled output toggles");
endmodule

// >>> clock_buffer_output_gating.sv
// apb and two-wire control of the zero delay clock buffer outputs
//
// How it works
// - mode_select high runs ddr group, low runs sdr group; other group off.
// - six ddr pairs or thirteen sdr outputs, all from one reference.
// - true ddr and sdr outputs copy the reference when enabled.
// - complement ddr outputs carry the inverted reference.
// - feedback outputs copy the reference to close the external loop.
// - an output with its enable bit cleared sits low.
// - feedback outputs have no enable and run whenever their mode is on.
// - enable registers load defaults at reset, no serial access needed.
// - serial data is sampled on rising edges of the host serial clock.
// - loop aligns output edges with reference via external feedback; here the feedback inputs only feed status bits.
// - slave answers at seven-bit address 1101001 plus direction bit.
// - command bit 7 low is block from offset 0, high is byte at offset.
//
// Chosen here: the APB interface to the registers and the address map.
`timescale 1ns/10ps
`include "clkbuf_defines.svh"
module clock_buffer_output_gating (
  // apb slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // clock pins
  input  wire logic        reference_clock_in,
  input  wire logic        mode_select,
  input  wire logic        ddr_feedback_in,
  input  wire logic        sdr_feedback_in,
  output logic [5:0]       ddr_true_out,
  output logic [5:0]       ddr_comp_out,
  output logic             ddr_feedback_out,
  output logic [12:0]      sdr_out,
  output logic             sdr_feedback_out,
  // two-wire serial pins, data is open drain
  input  wire logic        serial_clock_in,
  input  wire logic        serial_data_in,
  output logic             serial_data_out,
  output logic             serial_data_oe_n
);
  import clkbuf_pkg::*;

  core_s state_q;
  core_s state_d;

  logic  scl_rise;
  logic  scl_fall;
  logic  start_ev;
  logic  stop_ev;
  logic  sda_now;
  logic  byte_end;
  logic  apb_setup;
  logic  apb_write;

  gate_if gates ();

  // enable byte at a serial offset, unused offsets read as zero
  function automatic logic [7:0] en_byte(core_s c, logic [6:0] idx);
    logic [7:0] b;
    b = 8'h00;
    unique case (idx)
      `IDX_ENABLE0: b = c.en0;
      `IDX_ENABLE1: b = c.en1;
      `IDX_ENABLE2: b = c.en2;
      default:      b = 8'h00;
    endcase
    return b;
  endfunction

  // store an enable byte, reserved bits kept at zero
  function automatic core_s put_byte(core_s c, logic [6:0] idx,
                                     logic [7:0] d);
    core_s r;
    r = c;
    unique case (idx)
      `IDX_ENABLE0: r.en0 = d & `RST_ENABLE0;
      `IDX_ENABLE1: r.en1 = d & `RST_ENABLE1;
      `IDX_ENABLE2: r.en2 = d & `RST_ENABLE2;
      default:      r = c;
    endcase
    r.touched = 1'b1;
    return r;
  endfunction

  // bus events straight from the apb pins, serial edges taken after the synchronisers
  assign apb_setup = psel & ~penable;
  assign apb_write = psel & penable & pwrite;
  assign sda_now   = state_q.sda_sy[1];
  assign scl_rise  = state_q.scl_sy[1] & ~state_q.scl_sy[2];
  assign scl_fall  = ~state_q.scl_sy[1] & state_q.scl_sy[2];
  assign start_ev  = state_q.scl_sy[1] & state_q.scl_sy[2]
                     & state_q.sda_sy[2] & ~state_q.sda_sy[1];
  assign stop_ev   = state_q.scl_sy[1] & state_q.scl_sy[2]
                     & ~state_q.sda_sy[2] & state_q.sda_sy[1];
  assign byte_end  = scl_fall & ~state_q.ack
                     & (state_q.bitcnt == `BITS_PER_BYTE);

  // next state of the whole block
  always_comb begin
    logic [3:0] status;
    logic       mapped;
    status = 4'h0;
    mapped = 1'b0;
    state_d = state_q;

    // pins pass two flops before any use
    state_d.mode_sy   = {state_q.mode_sy[0], mode_select};
    state_d.ddr_fb_sy = {state_q.ddr_fb_sy[0], ddr_feedback_in};
    state_d.sdr_fb_sy = {state_q.sdr_fb_sy[0], sdr_feedback_in};
    state_d.scl_sy    = {state_q.scl_sy[1:0], serial_clock_in};
    state_d.sda_sy    = {state_q.sda_sy[1:0], serial_data_in};

    // status word shows the synchronised pins and the serial activity
    status[`ST_MODE]     = state_q.mode_sy[1];
    status[`ST_DDR_FB]   = state_q.ddr_fb_sy[1];
    status[`ST_SDR_FB]   = state_q.sdr_fb_sy[1];
    status[`ST_SER_BUSY] = (state_q.phase != PH_IDLE);

    // apb read data and error are prepared in the setup cycle
    mapped = (paddr[1:0] == 2'b00) && (paddr[11:2] < 10'h003);
    if (apb_setup) begin
      state_d.pslverr = 1'b0;
      state_d.prdata  = 32'h0000_0000;
      if (paddr == `OFS_STATUS) begin
        state_d.prdata = {28'h000_0000, status};
      end else if (mapped) begin
        state_d.prdata = {24'h00_0000, en_byte(state_q, paddr[8:2])};
      end else begin
        state_d.pslverr = 1'b1;
      end
    end

    // apb write lands in the access cycle, pready is always high
    if (apb_write && mapped) begin
      state_d = put_byte(state_d, paddr[8:2], pwdata[7:0]);
    end

    // two-wire slave; its write comes after apb and wins on a clash
    if (start_ev) begin
      state_d.phase    = PH_ADDR;
      state_d.bitcnt   = 4'h0;
      state_d.ack      = 1'b0;
      state_d.sda_oe_n = 1'b1;
    end else if (stop_ev) begin
      state_d.phase    = PH_IDLE;
      state_d.ack      = 1'b0;
      state_d.sda_oe_n = 1'b1;
    end else if (scl_rise) begin
      if (state_q.ack) begin
        // host answer to a sent byte: high means no more wanted
        if (state_q.phase == PH_RDATA && sda_now) begin
          state_d.phase = PH_SKIP;
        end
      end else if (state_q.phase != PH_IDLE
                   && state_q.phase != PH_SKIP) begin
        if (state_q.phase != PH_RDATA) begin
          state_d.shift = {state_q.shift[6:0], sda_now};
        end
        state_d.bitcnt = state_q.bitcnt + 4'h1;
      end
    end else if (scl_fall) begin
      if (state_q.ack) begin
        // end of an acknowledge slot
        state_d.ack      = 1'b0;
        state_d.bitcnt   = 4'h0;
        state_d.sda_oe_n = 1'b1;
        if (state_q.phase == PH_RDATA) begin
          // block read opens with the byte count
          if (state_q.rd_first) begin
            state_d.shift    = `BLOCK_COUNT;
            state_d.rd_first = 1'b0;
          end else begin
            state_d.shift = en_byte(state_q, state_q.ptr);
            state_d.ptr   = state_q.ptr + 7'h01;
          end
          state_d.sda_oe_n = state_d.shift[7];
        end
      end else if (byte_end) begin
        unique case (state_q.phase)
          PH_ADDR: begin
            if (state_q.shift[7:1] == `SER_ADDR) begin
              state_d.ack      = 1'b1;
              state_d.sda_oe_n = 1'b0;
              if (state_q.shift[0]) begin
                state_d.phase    = PH_RDATA;
                state_d.rd_first = ~state_q.cmd[`CMD_BYTE_BIT];
              end else begin
                state_d.phase = PH_CMD;
              end
            end else begin
              state_d.phase = PH_SKIP;
            end
          end
          PH_CMD: begin
            state_d.cmd      = state_q.shift;
            state_d.ack      = 1'b1;
            state_d.sda_oe_n = 1'b0;
            if (state_q.shift[`CMD_BYTE_BIT]) begin
              state_d.ptr   = state_q.shift[6:0];
              state_d.phase = PH_WDATA;
            end else begin
              state_d.ptr   = 7'h00;
              state_d.phase = PH_COUNT;
            end
          end
          PH_COUNT: begin
            // count is taken but the stop ends the block anyway
            state_d.ack      = 1'b1;
            state_d.sda_oe_n = 1'b0;
            state_d.phase    = PH_WDATA;
          end
          PH_WDATA: begin
            state_d          = put_byte(state_d, state_q.ptr,
                                        state_q.shift);
            state_d.ptr      = state_q.ptr + 7'h01;
            state_d.ack      = 1'b1;
            state_d.sda_oe_n = 1'b0;
          end
          PH_RDATA: begin
            // release the line for the host acknowledge
            state_d.ack      = 1'b1;
            state_d.sda_oe_n = 1'b1;
          end
          PH_IDLE, PH_SKIP: begin
            state_d.bitcnt = state_q.bitcnt;
          end
        endcase
      end else if (state_q.phase == PH_RDATA) begin
        // next bit of a sent byte, most significant first
        state_d.shift    = {state_q.shift[6:0], 1'b0};
        state_d.sda_oe_n = state_d.shift[7];
      end
    end
  end

  // one register for the whole state, defaults at reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q           <= '0;
      state_q.scl_sy    <= 3'h7;
      state_q.sda_sy    <= 3'h7;
      state_q.en0       <= `RST_ENABLE0;
      state_q.en1       <= `RST_ENABLE1;
      state_q.en2       <= `RST_ENABLE2;
      state_q.phase     <= PH_IDLE;
      state_q.sda_oe_n  <= 1'b1;
    end else begin
      state_q <= state_d;
    end
  end

  // apb answer: no wait states
  assign pready           = 1'b1;
  assign prdata           = state_q.prdata;
  assign pslverr          = state_q.pslverr;

  // open drain data line only ever pulls low
  assign serial_data_out  = 1'b0;
  assign serial_data_oe_n = state_q.sda_oe_n;

  // enable bytes split onto the output groups
  assign gates.ddr_mode   = state_q.mode_sy[1];
  assign gates.en_sdr     = {state_q.en1[4:0], state_q.en0};
  assign gates.en_ddr     = state_q.en2[5:0];

  // output gating of the reference clock
  clock_gate_array u_gates (
    .pclk               (pclk),
    .presetn            (presetn),
    .reference_clock_in (reference_clock_in),
    .g                  (gates.gate),
    .ddr_true_out       (ddr_true_out),
    .ddr_comp_out       (ddr_comp_out),
    .ddr_feedback_out   (ddr_feedback_out),
    .sdr_out            (sdr_out),
    .sdr_feedback_out   (sdr_feedback_out)
  );

  AST_DEFAULTS_HELD: assert property (
    @(posedge pclk) disable iff (!presetn)
    !state_q.touched |-> (state_q.en0 == `RST_ENABLE0
                          && state_q.en1 == `RST_ENABLE1
                          && state_q.en2 == `RST_ENABLE2))
    else $error("enable bytes left their defaults without a write");

  AST_SAMPLE_ON_RISE: assert property (
    @(posedge pclk) disable iff (!presetn)
    (scl_rise && !start_ev && !stop_ev && !state_q.ack
     && (state_q.phase inside {PH_ADDR, PH_CMD, PH_COUNT, PH_WDATA}))
    |=> (state_q.shift[0] == $past(sda_now)
         && state_q.bitcnt == $past(state_q.bitcnt) + 4'h1))
    else $error("serial bit not sampled on clock rise");

  AST_ADDR_ACK: assert property (
    @(posedge pclk) disable iff (!presetn)
    (byte_end && state_q.phase == PH_ADDR
     && state_q.shift[7:1] == `SER_ADDR)
    |=> (!serial_data_oe_n && state_q.ack) [*1] ##1
        (state_q.ack || state_q.phase != PH_IDLE))
    else $error("own address not acknowledged");

  AST_ADDR_MISS: assert property (
    @(posedge pclk) disable iff (!presetn)
    (byte_end && state_q.phase == PH_ADDR
     && state_q.shift[7:1] != `SER_ADDR)
    |=> (state_q.phase == PH_SKIP && serial_data_oe_n))
    else $error("foreign address acknowledged");

  AST_CMD_BYTE_OFFSET: assert property (
    @(posedge pclk) disable iff (!presetn)
    (byte_end && state_q.phase == PH_CMD && state_q.shift[7])
    |=> (state_q.ptr == $past(state_q.shift[6:0])
         && state_q.phase == PH_WDATA))
    else $error("byte command did not load its offset");

  AST_CMD_BLOCK_ZERO: assert property (
    @(posedge pclk) disable iff (!presetn)
    (byte_end && state_q.phase == PH_CMD && !state_q.shift[7])
    |=> (state_q.ptr == 7'h00 && state_q.phase == PH_COUNT))
    else $error("block command did not start at offset zero");

  // host refusal after a sent byte stops the read
  AST_NACK_ENDS_READ: assert property (
    @(posedge pclk) disable iff (!presetn)
    (scl_rise && state_q.ack && state_q.phase == PH_RDATA && sda_now)
    |=> (state_q.phase == PH_SKIP))
    else $error("host refusal did not end the read");

  // a block read sends the byte count before any enable byte
  AST_COUNT_LEADS: assert property (
    @(posedge pclk) disable iff (!presetn)
    (scl_fall && state_q.ack && state_q.phase == PH_RDATA
     && state_q.rd_first)
    |=> (state_q.shift == `BLOCK_COUNT && !state_q.rd_first))
    else $error("block read did not open with the byte count");
endmodule

// >>> serial_host_model.sv
// two-wire host and reference clock source facing the buffer
`timescale 1ns/10ps
module serial_host_model (
  // pacing clock
  input  wire logic pclk,
  // device pull on the data line
  input  wire logic serial_data_oe_n,
  // driven pins
  output logic      reference_clock_in,
  output logic      serial_clock_in,
  output logic      serial_data_in
);
  logic sda_q; // host drive, 1 = released

  // free running reference, unrelated to pclk
  initial begin
    reference_clock_in = 1'b0;
    forever #17 reference_clock_in = ~reference_clock_in;
  end

  // idle bus: both lines pulled high, clock stands still
  initial begin
    sda_q = 1'b1;
    serial_clock_in = 1'b1;
  end

  // pulled-up wire: low when either party pulls
  assign serial_data_in = sda_q & serial_data_oe_n;

  // waits n control clock edges
  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // start or repeated start: data falls while clock high
  task automatic start();
    wt(1);
    sda_q <= 1'b1;
    wt(6);
    serial_clock_in <= 1'b1;
    wt(6);
    sda_q <= 1'b0;
    wt(6);
    serial_clock_in <= 1'b0;
    wt(6);
  endtask

  // stop: data rises while clock high
  task automatic stop();
    sda_q <= 1'b0;
    wt(6);
    serial_clock_in <= 1'b1;
    wt(6);
    sda_q <= 1'b1;
    wt(12);
  endtask

  // nine bits msb first, wire sampled while clock high
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      sda_q <= tx[i];
      wt(8);
      serial_clock_in <= 1'b1;
      wt(8);
      rx[i] = serial_data_in;
      serial_clock_in <= 1'b0;
    end
    wt(2);
  endtask
endmodule

// >>> tb.sv
// self-checking bench for the clock buffer output gating
`timescale 1ns/10ps
`include "clkbuf_defines.svh"
`define CHK(nm, ex, got) \
  begin \
    checks_done++; \
    if ((got) !== (ex)) begin \
      n_errors++; \
      $display("wrong value %s expected %h seen %h", nm, ex, got); \
    end \
  end
module tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic        reference_clock_in, mode_select, ddr_fb, sdr_fb;
  logic [5:0]  ddr_true_out, ddr_comp_out;
  logic [12:0] sdr_out;
  logic        scl, sda, sda_oe_n, e, sda_dout;
  logic [8:0]  rx;
  logic [7:0]  blk [3];
  int          n_errors, checks_done;

  // design and far-side host
  clock_buffer_output_gating dut_u (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .reference_clock_in(reference_clock_in), .mode_select(mode_select),
    .ddr_feedback_in(ddr_fb), .sdr_feedback_in(sdr_fb),
    .ddr_true_out(ddr_true_out), .ddr_comp_out(ddr_comp_out),
    .ddr_feedback_out(ddr_fb), .sdr_out(sdr_out),
    .sdr_feedback_out(sdr_fb), .serial_clock_in(scl),
    .serial_data_in(sda), .serial_data_out(sda_dout),
    .serial_data_oe_n(sda_oe_n));
  serial_host_model host_u (
    .pclk(pclk), .serial_data_oe_n(sda_oe_n),
    .reference_clock_in(reference_clock_in),
    .serial_clock_in(scl), .serial_data_in(sda));

  // 20 MHz control clock
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // verdict and end of run
  task automatic conclude();
    if (n_errors == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // one apb transfer, held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= wr;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge pclk);
    end
    if (n == 20) begin
      n_errors++;
      conclude();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // register read and compare
  task automatic rd(input logic [11:0] a, input logic [31:0] ex);
    apb(1'b0, a, 32'h0);
    `CHK("prdata", ex, q)
    `CHK("pslverr", 1'b0, e)
  endtask

  // one byte to the slave, ack level expected
  task automatic sb(input logic [7:0] b, input logic ak);
    host_u.xfer({b, 1'b1}, rx);
    `CHK("ack", ak, rx[0])
  endtask

  // clock outputs at both reference levels
  task automatic outs(input logic m, input logic [12:0] es,
                      input logic [5:0] ed);
    logic r;
    for (int p = 0; p < 2; p++) begin
      if (p == 0) begin
        @(posedge reference_clock_in);
      end else begin
        @(negedge reference_clock_in);
      end
      #3;
      r = reference_clock_in;
      `CHK("ddr_true", (m ? ed & {6{r}} : 6'h00), ddr_true_out)
      `CHK("ddr_comp", (m ? ed & {6{~r}} : 6'h00), ddr_comp_out)
      `CHK("ddr_fb", (m & r), ddr_fb)
      `CHK("sdr", (m ? 13'h0000 : es & {13{r}}), sdr_out)
      `CHK("sdr_fb", (~m & r), sdr_fb)
    end
  endtask

  // hang guard
  initial begin
    repeat (100000) @(posedge pclk);
    n_errors++;
    conclude();
  end

  // main sequence
  initial begin
    n_errors = 0;
    checks_done = 0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    mode_select = 1'b0;
    presetn = 1'b0;
    blk = '{8'h03, 8'h11, 8'h02};
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    rd(`OFS_ENABLE0, 32'h000000FF);
    rd(`OFS_ENABLE1, 32'h0000001F);
    rd(`OFS_ENABLE2, 32'h0000003F);
    outs(1'b0, 13'h1FFF, 6'h3F);
    apb(1'b1, 12'h010, 32'h0);
    `CHK("pslverr", 1'b1, e)
    apb(1'b0, 12'h010, 32'h0);
    `CHK("pslverr", 1'b1, e)
    `CHK("prdata", 32'h0, q)
    wr_and_check();
    outs(1'b0, 13'h0A0F, 6'h3F);
    apb(1'b1, `OFS_ENABLE2, 32'h0000002A);
    mode_select <= 1'b1;
    repeat (4) @(posedge pclk);
    apb(1'b0, `OFS_STATUS, 32'h0);
    `CHK("mode", 1'b1, q[`ST_MODE])
    `CHK("status", 2'b00, q[`ST_SER_BUSY:`ST_SDR_FB])
    outs(1'b1, 13'h0A0F, 6'h2A);
    host_u.start();
    apb(1'b0, `OFS_STATUS, 32'h0);
    `CHK("busy", 1'b1, q[`ST_SER_BUSY])
    sb(8'hD2, 1'b0);
    sb(8'h82, 1'b0);
    sb(8'h15, 1'b0);
    host_u.stop();
    rd(`OFS_ENABLE2, 32'h00000015);
    outs(1'b1, 13'h0A0F, 6'h15);
    host_u.start();
    sb(8'hD2, 1'b0);
    sb(8'h00, 1'b0);
    foreach (blk[i]) sb(blk[i] + 8'h0, 1'b0);
    sb(8'h33, 1'b0);
    host_u.stop();
    rd(`OFS_ENABLE0, 32'h00000011);
    rd(`OFS_ENABLE1, 32'h00000002);
    rd(`OFS_ENABLE2, 32'h00000033);
    host_u.start();
    sb(8'hD4, 1'b1);
    sb(8'h80, 1'b1);
    sb(8'h00, 1'b1);
    host_u.stop();
    rd(`OFS_ENABLE0, 32'h00000011);
    host_u.start();
    sb(8'hD2, 1'b0);
    sb(8'h82, 1'b0);
    host_u.start();
    sb(8'hD3, 1'b0);
    host_u.xfer(9'h1FF, rx);
    `CHK("byte_read", 8'h33, rx[8:1])
    host_u.stop();
    host_u.start();
    sb(8'hD2, 1'b0);
    sb(8'h00, 1'b0);
    host_u.start();
    sb(8'hD3, 1'b0);
    for (int i = 0; i < 3; i++) begin
      host_u.xfer({8'hFF, i == 2}, rx);
      `CHK("block_read", blk[i], rx[8:1])
    end
    host_u.stop();
    mode_select <= 1'b0;
    repeat (4) @(posedge pclk);
    outs(1'b0, 13'h0211, 6'h33);
    `CHK("sda_out", 1'b0, sda_dout)
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    rd(`OFS_ENABLE0, 32'h000000FF);
    outs(1'b0, 13'h1FFF, 6'h3F);
    conclude();
  end

  // apb writes with ignored upper and reserved bits
  task automatic wr_and_check();
    apb(1'b1, `OFS_ENABLE0, 32'hFFFFFF0F);
    apb(1'b1, `OFS_ENABLE1, 32'h000000EA);
    rd(`OFS_ENABLE0, 32'h0000000F);
    rd(`OFS_ENABLE1, 32'h0000000A);
  endtask
endmodule
